// [fpep_ctrl_props.sv]
// Concurrent checks on the ports of the flash sequencer.
// Assumes it is bound to fpep_flash_ctrl and sees nothing but its ports.
`timescale 1ns/1ns
`default_nettype none
module fpep_ctrl_props
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Wishbone slave.
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [15:0] i_wb_adr,
	input wire logic [7:0] i_wb_dat,
	input wire logic i_wb_sel,
	input wire logic [7:0] o_wb_dat,
	input wire logic o_wb_ack,
	// Storage array port.
	input wire logic [15:0] o_mem_addr,
	input wire logic o_mem_we,
	input wire logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata,
	// Charge pump and status.
	input wire logic o_hv_enable,
	input wire logic o_erase_busy
);
	logic [7:0] prot_reg;
	// Mirrors the protect byte as last read, since the block only trusts a fresh read.
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
		if (!i_reset_n)
			prot_reg <= 8'h00;
		else if (o_wb_ack && !i_wb_we && i_wb_adr == 16'hff80)
			prot_reg <= o_wb_dat;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	property p_hv_cause; $rose(o_hv_enable) |-> $past(i_wb_cyc && i_wb_stb && i_wb_we
		&& i_wb_adr == 16'hff88 && i_wb_dat[3] && (i_wb_dat[1] || i_wb_dat[0])); endproperty
	a_hv_cause: assert property (p_hv_cause) else $error("pump on without cause");
	property p_reset; $rose(i_reset_n) |-> !o_hv_enable && !o_erase_busy && !o_wb_ack; endproperty
	a_reset: assert property (p_reset) else $error("armed after reset");
	property p_reg_ack; $rose(i_wb_stb) && i_wb_adr == 16'hff88 |=> o_wb_ack; endproperty
	a_reg_ack: assert property (p_reg_ack) else $error("control ack late");
	property p_arr_ack; $rose(i_wb_stb) && i_wb_adr[15] && i_wb_adr != 16'hff88
		&& !o_erase_busy |-> !o_wb_ack ##1 !o_wb_ack ##1 o_wb_ack; endproperty
	a_arr_ack: assert property (p_arr_ack) else $error("array ack timing");
	property p_unmapped; o_wb_ack && !i_wb_we && !i_wb_adr[15] |-> o_wb_dat == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
	property p_prog_and; o_mem_we && o_wb_ack && !$past(o_erase_busy) |-> o_mem_addr == i_wb_adr
		&& o_mem_wdata == $past(i_mem_rdata & i_wb_dat); endproperty
	a_prog_and: assert property (p_prog_and) else $error("program sets bits");
	// Erase strobes trail the busy flag by one cycle, so the last byte is seen through $past.
	property p_erase_ones; o_mem_we && $past(o_erase_busy) |-> o_mem_wdata == 8'hff; endproperty
	a_erase_ones: assert property (p_erase_ones) else $error("erase not ones");
	property p_we_hv; o_mem_we |-> o_hv_enable; endproperty
	a_we_hv: assert property (p_we_hv) else $error("array write with pump off");
	property p_prot; o_mem_we |-> prot_reg == 8'hff || o_mem_addr < {1'b1, prot_reg, 7'h00}; endproperty
	a_prot: assert property (p_prot) else $error("protected write");
	c_hv: cover property ($rose(o_hv_enable));
	c_erase: cover property ($fell(o_erase_busy));
	c_prog: cover property (o_mem_we && o_wb_ack);
endmodule : fpep_ctrl_props
bind fpep_flash_ctrl fpep_ctrl_props i_props (.i_sys_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb,
	.i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .o_mem_addr, .o_mem_we,
	.o_mem_wdata, .i_mem_rdata, .o_hv_enable, .o_erase_busy);
`default_nettype wire

// [fpep_flash_ctrl.sv]
// Flash sequencer: control register, protect decode, program and erase engine.
// Assumes a classic Wishbone master on i_sys_clk and a byte array with combinational read.

`timescale 1ns/1ns
`default_nettype none

module fpep_flash_ctrl
	import fpep_pkg::*;
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Wishbone slave.
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [15:0] i_wb_adr,
	input wire logic [7:0] i_wb_dat,
	input wire logic i_wb_sel,
	output logic [7:0] o_wb_dat,
	output logic o_wb_ack,
	// Storage array port.
	output logic [15:0] o_mem_addr,
	output logic o_mem_we,
	output logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata,
	// Charge pump and status.
	output logic o_hv_enable,
	output logic o_erase_busy
);

	function automatic logic in_protect(input logic [15:0] addr, input logic [7:0] start);
		logic hit;
		hit = 1'b0;
		if (start != FPEP_PROTECT_NONE)
		begin
			hit = addr[15] && (addr[14:0] >= {start, FPEP_PAGE_FIRST});
		end
		return hit;
	endfunction : in_protect

	fpep_bus_t bus_state_reg;
	logic wb_ack_reg;
	logic [7:0] wb_dat_reg;
	logic [15:0] mem_addr_reg;
	logic mem_we_reg;
	logic [7:0] mem_wdata_reg;
	logic hv_reg;
	logic mass_reg;
	logic erase_reg;
	logic program_reg;
	logic [7:0] protect_reg;
	logic protect_seen_reg;
	logic armed_reg;
	logic arm_prot_reg;
	logic [15:0] arm_addr_reg;
	logic erasing_reg;
	logic erase_done_reg;
	logic [15:0] erase_ptr_reg;
	logic [15:0] erase_end_reg;

	wire req = i_wb_cyc && i_wb_stb && !wb_ack_reg;
	wire ctrl_hit = (i_wb_adr == FPEP_FLASH_OP_CONTROL_OFS);
	wire protect_hit = (i_wb_adr == FPEP_PROTECT_START_OFS);
	wire array_hit = i_wb_adr[15] && !ctrl_hit;
	wire bus_idle = (bus_state_reg == FPEP_BUS_IDLE);
	wire take_reg = bus_idle && req && !array_hit;
	wire take_mem = bus_idle && req && array_hit && !erasing_reg;
	wire in_mem = (bus_state_reg == FPEP_BUS_MEM);
	wire ctrl_write = take_reg && ctrl_hit && i_wb_we && i_wb_sel;
	wire mem_write = in_mem && i_wb_we && i_wb_sel;
	wire mem_read = in_mem && !i_wb_we;
	wire addr_protected = in_protect(i_wb_adr, protect_reg);

	// Interlock: a write asking for both selects leaves both as they were.
	wire want_erase = i_wb_dat[FPEP_ERASE_BIT];
	wire want_program = i_wb_dat[FPEP_PROGRAM_BIT];
	wire both_wanted = want_erase && want_program;
	wire erase_next = ctrl_write ? (both_wanted ? erase_reg : want_erase) : erase_reg;
	wire program_next = ctrl_write ? (both_wanted ? program_reg : want_program) : program_reg;
	wire mass_next = ctrl_write ? i_wb_dat[FPEP_MASS_BIT] : mass_reg;
	wire selected = erase_reg || program_reg;
	wire selected_next = erase_next || program_next;

	// High voltage is refused when erase and mass are selected before the enabling write and any part of the array is protected.
	wire mass_blocked = erase_reg && mass_reg && (protect_reg != FPEP_PROTECT_NONE);
	wire hv_allowed = selected && protect_seen_reg && armed_reg && !arm_prot_reg && !mass_blocked;
	wire hv_next = ctrl_write ? (i_wb_dat[FPEP_HIGH_VOLTAGE_ENABLE_BIT] && (hv_reg || hv_allowed)) : hv_reg;

	wire arm_now = mem_write && !hv_reg && selected && protect_seen_reg && !armed_reg;
	wire same_row = (i_wb_adr[15:FPEP_ROW_LSB] == arm_addr_reg[15:FPEP_ROW_LSB]);
	wire program_byte = mem_write && hv_reg && program_reg && armed_reg && !arm_prot_reg &&
		same_row && !addr_protected;

	wire [15:0] erase_first = mass_reg ? FPEP_ARRAY_BASE :
		{arm_addr_reg[15:FPEP_PAGE_LSB], FPEP_PAGE_FIRST};
	wire [15:0] erase_last = mass_reg ? FPEP_SPACE_TOP :
		{arm_addr_reg[15:FPEP_PAGE_LSB], FPEP_PAGE_LAST};
	wire erase_start = hv_reg && erase_reg && armed_reg && !arm_prot_reg && !erase_done_reg &&
		!erasing_reg && bus_idle && !take_mem;
	wire erase_final = erasing_reg && (erase_ptr_reg == erase_end_reg);

	wire [7:0] ctrl_read = {4'h0, hv_reg, mass_reg, erase_reg, program_reg};
	wire [7:0] reg_read = ctrl_hit ? ctrl_read : FPEP_UNMAPPED_READ;

	// Bus phase. Array accesses take one extra cycle for the array read.
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			bus_state_reg <= FPEP_BUS_IDLE;
		end
		else if (take_mem)
		begin
			bus_state_reg <= FPEP_BUS_MEM;
		end
		else
		begin
			bus_state_reg <= FPEP_BUS_IDLE;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 8'h00;
		end
		else
		begin
			wb_ack_reg <= take_reg || in_mem;
			if (take_reg)
			begin
				wb_dat_reg <= reg_read;
			end
			else if (mem_read)
			begin
				wb_dat_reg <= i_mem_rdata;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			hv_reg <= FPEP_CONTROL_BIT_RESET;
			mass_reg <= FPEP_CONTROL_BIT_RESET;
			erase_reg <= FPEP_CONTROL_BIT_RESET;
			program_reg <= FPEP_CONTROL_BIT_RESET;
		end
		else
		begin
			hv_reg <= hv_next;
			mass_reg <= mass_next;
			erase_reg <= erase_next;
			program_reg <= program_next;
		end
	end

	// The protect byte is only ever copied from the array, never written here.
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			protect_reg <= FPEP_PROTECT_RESET;
		end
		else if (mem_read && protect_hit)
		begin
			protect_reg <= i_mem_rdata;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			protect_seen_reg <= 1'b0;
		end
		else if (!selected_next)
		begin
			protect_seen_reg <= 1'b0;
		end
		else if (mem_read && protect_hit && selected)
		begin
			protect_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			armed_reg <= 1'b0;
			arm_prot_reg <= 1'b0;
			arm_addr_reg <= 16'h0000;
		end
		else if (!selected_next)
		begin
			armed_reg <= 1'b0;
			arm_prot_reg <= 1'b0;
		end
		else if (arm_now)
		begin
			armed_reg <= 1'b1;
			arm_prot_reg <= addr_protected;
			arm_addr_reg <= i_wb_adr;
		end
	end

	// Erase walks the page or the whole space writing erased bytes, one per cycle.
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			erasing_reg <= 1'b0;
			erase_ptr_reg <= 16'h0000;
			erase_end_reg <= 16'h0000;
		end
		else if (erasing_reg && (!hv_reg || erase_final))
		begin
			erasing_reg <= 1'b0;
		end
		else if (erase_start)
		begin
			erasing_reg <= 1'b1;
			erase_ptr_reg <= erase_first;
			erase_end_reg <= erase_last;
		end
		else if (erasing_reg)
		begin
			erase_ptr_reg <= erase_ptr_reg + 16'h0001;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			erase_done_reg <= 1'b0;
		end
		else if (!hv_reg || !erase_reg)
		begin
			erase_done_reg <= 1'b0;
		end
		else if (erase_final)
		begin
			erase_done_reg <= 1'b1;
		end
	end

	// Array port. Programming ANDs new data into the old byte so only zeros are written.
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			mem_addr_reg <= FPEP_ARRAY_BASE;
			mem_we_reg <= 1'b0;
			mem_wdata_reg <= FPEP_ERASED_BYTE;
		end
		else if (erasing_reg)
		begin
			mem_addr_reg <= erase_ptr_reg;
			mem_we_reg <= 1'b1;
			mem_wdata_reg <= FPEP_ERASED_BYTE;
		end
		else if (take_mem)
		begin
			mem_addr_reg <= i_wb_adr;
			mem_we_reg <= 1'b0;
		end
		else if (program_byte)
		begin
			mem_we_reg <= 1'b1;
			mem_wdata_reg <= i_mem_rdata & i_wb_dat;
		end
		else
		begin
			mem_we_reg <= 1'b0;
		end
	end

	assign o_wb_ack = wb_ack_reg;
	assign o_wb_dat = wb_dat_reg;
	assign o_mem_addr = mem_addr_reg;
	assign o_mem_we = mem_we_reg;
	assign o_mem_wdata = mem_wdata_reg;
	assign o_hv_enable = hv_reg;
	assign o_erase_busy = erasing_reg;

endmodule : fpep_flash_ctrl

`default_nettype wire

// [fpep_mem_model.sv]
// Byte array standing behind the sequencer's storage port.
// Assumes one byte written per strobed cycle and a combinational read.
`timescale 1ns/1ns
`default_nettype none
module fpep_mem_model
(
	// Clock.
	input wire logic i_clk,
	// Array port.
	input wire logic [15:0] i_addr,
	input wire logic i_we,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem_reg [0:32767];
	initial
	begin
		foreach (mem_reg[k])
			mem_reg[k] = 8'hff;
	end
	// protect byte lives in the array.
	always @(posedge i_clk)
		if (i_we)
			mem_reg[i_addr[14:0]] <= i_wdata;
	assign o_rdata = mem_reg[i_addr[14:0]];
endmodule : fpep_mem_model
`default_nettype wire

// [fpep_pkg.sv]
// Constants, field layout and state types for the flash program, erase and protect block.
// Assumes a byte-wide storage array outside this block, read combinationally on its address.
//
// Functional notes
// - Erased bits read one; programming can only clear bits to zero.
// - Pages are two 64-byte rows; a page of 128 bytes is the least erase.
// - One programming cycle writes bytes only within a single 64-byte row.
// - Array 8000 to FDFF; protect byte at FF80; control register at FF88.
// - High-voltage enable sets only with program or erase selected and sequence followed.
// - Whole-array select one means mass erase, zero means page erase.
// - Erase and program selects are never both one, nor set together.
// - The protect byte lives in the array; only array programming or erase changes it.
// - Protect byte gives start bits 14 to 7; bit 15 one, low seven zero.
// - Protection spans from the start address up to FFFF inclusive.
// - Each decrement of the protect byte adds one 128-byte page.
// - Protect byte FF disables protection entirely.
// - Protect byte FE protects FF00 to FFFF, 256 bytes.
// - Protect byte 00 protects everything from 8000 upward.
// - High-voltage enable refuses to set when the addressed area is protected.
// - Protection decodes addresses alike whether or not array exists there.
// - Erasing the vector page, by page or mass, also erases the protect byte.
// - An erase armed at a protected address never takes place.
// - Program select enables latching address and data of later array writes.

package fpep_pkg;

	localparam logic [15:0] FPEP_PROTECT_START_OFS = 16'hff80;
	localparam logic [15:0] FPEP_FLASH_OP_CONTROL_OFS = 16'hff88;
	localparam logic [15:0] FPEP_ARRAY_BASE = 16'h8000;
	localparam logic [15:0] FPEP_ARRAY_TOP = 16'hfdff;
	localparam logic [15:0] FPEP_SPACE_TOP = 16'hffff;

	localparam int FPEP_ROW_LSB = 6;
	localparam int FPEP_PAGE_LSB = 7;
	localparam logic [6:0] FPEP_PAGE_LAST = 7'h7f;
	localparam logic [6:0] FPEP_PAGE_FIRST = 7'h00;

	localparam int FPEP_HIGH_VOLTAGE_ENABLE_BIT = 3;
	localparam int FPEP_MASS_BIT = 2;
	localparam int FPEP_ERASE_BIT = 1;
	localparam int FPEP_PROGRAM_BIT = 0;

	localparam logic FPEP_CONTROL_BIT_RESET = 1'b0;
	localparam logic [7:0] FPEP_PROTECT_RESET = 8'h00;
	localparam logic [7:0] FPEP_PROTECT_NONE = 8'hff;
	localparam logic [7:0] FPEP_ERASED_BYTE = 8'hff;
	localparam logic [7:0] FPEP_UNMAPPED_READ = 8'h00;

	typedef enum logic [1:0]
	{
		FPEP_BUS_IDLE = 2'b00,
		FPEP_BUS_MEM = 2'b01
	} fpep_bus_t;

endpackage : fpep_pkg

// [tb_flash_program_erase_protect.sv]
// Self-checking bench for the flash sequencer over Wishbone.
// Assumes the array model answers reads at once and starts fully erased.
`timescale 1ns/1ns
`default_nettype none
module tb_flash_program_erase_protect;
	logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic i_wb_sel = 1'b1;
	logic [15:0] i_wb_adr = 16'h0000;
	logic [7:0] i_wb_dat = 8'h00;
	logic [7:0] o_wb_dat, o_mem_wdata, i_mem_rdata, q;
	logic o_wb_ack, o_mem_we, o_hv_enable, o_erase_busy;
	logic [15:0] o_mem_addr;
	int n_fail = 0;
	int n_tests = 0;
	always #25 i_sys_clk = ~i_sys_clk;
	fpep_flash_ctrl i_dut (.i_sys_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
		.i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .o_mem_addr, .o_mem_we, .o_mem_wdata,
		.i_mem_rdata, .o_hv_enable, .o_erase_busy);
	fpep_mem_model i_mem (.i_clk(i_sys_clk), .i_addr(o_mem_addr), .i_we(o_mem_we),
		.i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	task wrap_up;
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, e);
		end
	endtask : chk
	// A mass erase holds the answer back for some 32768 cycles, hence the wide bound.
	task wb(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= d;
		do
		begin
			@(posedge i_sys_clk);
			n++;
		end
		while (o_wb_ack !== 1'b1 && n < 40000);
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		if (n >= 40000)
		begin
			n_fail++;
			wrap_up();
		end
		@(posedge i_sys_clk);
	endtask : wb
	task rd(input logic [15:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(q, e);
	endtask : rd
	task prog(input logic [15:0] arm, input logic [15:0] a, input logic [7:0] d, input logic ok);
		wb(1'b1, 16'hff88, 8'h01);
		wb(1'b0, 16'hff80, 8'h00);
		wb(1'b1, arm, 8'hff);
		wb(1'b1, 16'hff88, 8'h09);
		rd(16'hff88, {4'h0, ok, 3'h1});
		wb(1'b1, a, d);
		wb(1'b1, 16'hff88, 8'h08);
		wb(1'b1, 16'hff88, 8'h00);
	endtask : prog
	task erase(input logic [7:0] c, input logic [15:0] a, input logic ok);
		wb(1'b1, 16'hff88, c);
		wb(1'b0, 16'hff80, 8'h00);
		wb(1'b1, a, 8'h00);
		wb(1'b1, 16'hff88, c | 8'h08);
		rd(16'hff88, c | {4'h0, ok, 3'h0});
		wb(1'b0, a, 8'h00);
		wb(1'b1, 16'hff88, 8'h08);
		wb(1'b1, 16'hff88, 8'h00);
	endtask : erase
	task t_regs;
		rd(16'hff88, 8'h00);
		i_wb_sel <= 1'b0;
		wb(1'b1, 16'hff88, 8'h02);
		i_wb_sel <= 1'b1;
		rd(16'hff88, 8'h00);
		wb(1'b1, 16'h0040, 8'h55);
		rd(16'h0040, 8'h00);
		wb(1'b1, 16'hff88, 8'hf6);
		rd(16'hff88, 8'h06);
		wb(1'b1, 16'hff88, 8'h01);
		wb(1'b1, 16'hff88, 8'h03);
		rd(16'hff88, 8'h01);
		wb(1'b1, 16'hff88, 8'h00);
	endtask : t_regs
	task t_prog;
		prog(16'h8000, 16'h8000, 8'h5a, 1'b1);
		prog(16'h8000, 16'h8000, 8'h0f, 1'b1);
		rd(16'h8000, 8'h0a);
		prog(16'h8040, 16'h8000, 8'h00, 1'b1);
		rd(16'h8000, 8'h0a);
		prog(16'h8080, 16'h8080, 8'h11, 1'b1);
		rd(16'h8080, 8'h11);
	endtask : t_prog
	task t_erase;
		erase(8'h02, 16'h8000, 1'b1);
		rd(16'h8000, 8'hff);
		rd(16'h8080, 8'h11);
		erase(8'h06, 16'h9000, 1'b1);
		rd(16'h8080, 8'hff);
	endtask : t_erase
	task t_protect;
		prog(16'hff80, 16'hff80, 8'hfe, 1'b1);
		rd(16'hff80, 8'hfe);
		prog(16'hff00, 16'hff00, 8'h00, 1'b0);
		rd(16'hff00, 8'hff);
		prog(16'hfe80, 16'hfe80, 8'h3c, 1'b1);
		rd(16'hfe80, 8'h3c);
		erase(8'h06, 16'h8000, 1'b0);
		rd(16'hfe80, 8'h3c);
	endtask : t_protect
	initial
	begin
		repeat (3) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		t_regs();
		t_prog();
		t_erase();
		t_protect();
		wrap_up();
	end
endmodule : tb_flash_program_erase_protect
`default_nettype wire
